/* core/asu_pkg.sv */
// asu_pkg: shared constants for the async serial unit
package asu_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] RX_CONTROL_OFS = 16'hfed0;
  localparam logic [15:0] TX_CONTROL_OFS = 16'hfed1;
  localparam logic [15:0] BAUD_RELOAD_OFS = 16'hfed2;
  localparam logic [15:0] TX_HOLDING_OFS = 16'hfed3;
  localparam logic [15:0] RX_HOLDING_OFS = 16'hfed4;
  localparam logic [7:0] RX_CONTROL_RST = 8'h00;
  localparam logic [7:0] TX_CONTROL_RST = 8'h00;
  localparam logic [7:0] BAUD_RELOAD_RST = 8'h00;
  localparam logic [7:0] TX_HOLDING_RST = 8'h00;
  localparam logic [7:0] RX_HOLDING_RST = 8'h00;
  // ----------------------------------------------------------------
  // rx_control fields
  // ----------------------------------------------------------------
  localparam int RXC_PRESCALE = 7;
  localparam int RXC_START_DET = 6;
  localparam int RXC_ACTIVE = 5;
  localparam int RXC_STOP_ERR = 4;
  localparam int RXC_SPARE = 3;
  localparam int RXC_NINTH = 2;
  localparam int RXC_DONE = 1;
  localparam int RXC_IRQ_EN = 0;
  // ----------------------------------------------------------------
  // tx_control fields
  // ----------------------------------------------------------------
  localparam int TXC_RUN = 7;
  localparam int TXC_LEN_NINE = 6;
  localparam int TXC_PIN_EN = 5;
  localparam int TXC_OUT_TYPE = 4;
  localparam int TXC_LEN_SEVEN = 3;
  localparam int TXC_NINTH = 2;
  localparam int TXC_LOADED = 1;
  localparam int TXC_IRQ_EN = 0;
  // ----------------------------------------------------------------
  // baud timing, in thirds of a clock cycle per half bit
  // ----------------------------------------------------------------
  localparam int BAUD_ACC_W = 13;
  localparam logic [BAUD_ACC_W-1:0] BAUD_STEP = 13'h0003;
  localparam logic [4:0] HALF_MUL_FAST = 5'h04;
  localparam logic [4:0] HALF_MUL_SLOW = 5'h10;
  // ----------------------------------------------------------------
  // frame shape
  // ----------------------------------------------------------------
  localparam int SHIFT_W = 11;
  localparam logic [3:0] LEN_SEVEN = 4'h7;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE = 4'h9;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} asu_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} asu_rx_e;
endpackage : asu_pkg

/* core/asu_baud_gen.sv */
// asu_baud_gen: reload baud generator giving half-bit enable pulses
`timescale 1ns/1ps
module asu_baud_gen (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clear,
  input wire logic [7:0] reload,
  input wire logic prescaleSel,
  output logic halfTick
);
  import asu_pkg::*;

  typedef struct packed {
    logic [BAUD_ACC_W-1:0] acc;
    logic tick;
  } asu_baud_s;

  asu_baud_s st_r;
  asu_baud_s st_nxt;
  logic [BAUD_ACC_W-1:0] threshold;
  logic [BAUD_ACC_W-1:0] sum;

  // ----------------------------------------------------------------
  // fractional divider
  // ----------------------------------------------------------------
  // counting in thirds keeps the 8/3 and 32/3 ratios exact over a frame
  always_comb begin
    st_nxt = st_r;
    threshold = BAUD_ACC_W'(({5'h00, reload} + 13'h0001) * (prescaleSel ? HALF_MUL_SLOW : HALF_MUL_FAST));
    sum = st_r.acc + BAUD_STEP;
    st_nxt.tick = 1'b0;
    if (clear) begin
      st_nxt.acc = '0;
    end else if (sum >= threshold) begin
      st_nxt.acc = sum - threshold;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.acc = sum;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign halfTick = st_r.tick;
endmodule : asu_baud_gen

/* core/asu_uart.sv */
// asu_uart: async serial unit with register port, transmitter and receiver
// Operation
// - stop bit low sets stop error flag
// - nine-bit mode loads ninth rx bit
// - abort loads second-to-last sampled bit instead
// - frame end sets done, copies rx data
// - no new receive before done flag set
// - rx irq when enable and done
// - run starts tx, auto clears, clear aborts
// - continuous tx re-arms with one-cycle gap
// - control write at frame end blocks re-arm
// - two length bits select 9/8/7 bits
// - tx and rx share length and baud
// - pin enable routes tx data unless direction
// - idle pin high or released per type
// - output type: push-pull or open drain
// - ninth tx bit from control register
// - loaded flag set cycle after run
// - cleared loaded flag re-arms next frame
// - tx irq when enable and loaded
// - baud counter reset when both idle
// - bit period (n+1) times 8/3 or 32/3
// - seven-bit receive clears holding bit 7
// - start edge begins rx, clear aborts
// - lsb first, no parity bit
// - continuous tx sends two stop bits
`timescale 1ns/1ps
module asu_uart (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [asu_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic rxPin,
  input wire logic txPortDirection,
  output logic txPinOut,
  output logic txPinOe,
  output logic rxIrq,
  output logic txIrq
);
  import asu_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rxCtl;
    logic [7:0] txCtl;
    logic [7:0] baudReload;
    logic [7:0] txHold;
    logic [7:0] rxHold;
    logic [7:0] rdData;
    asu_tx_e txState;
    logic [SHIFT_W-1:0] txShift;
    logic [3:0] txCnt;
    logic txHalf;
    logic txExtra;
    asu_rx_e rxState;
    logic [SHIFT_W-1:0] rxShift;
    logic [3:0] rxCnt;
    logic rxSkip;
    logic rxLast;
    logic rxPrev;
    logic rxPinPrev;
    logic startDetPrev;
  } asu_state_s;

  asu_state_s st_r;
  asu_state_s st_nxt;
  logic halfTick;
  logic baudClear;
  logic wrRxCtl;
  logic wrTxCtl;
  logic [3:0] dataLen;
  logic [3:0] rxSamples;
  logic [SHIFT_W-1:0] frameBits;
  logic [SHIFT_W-1:0] rxShifted;
  logic rxEnd;
  logic rxAbort;
  logic startSeen;
  logic txLine;
  logic pinRouted;

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // one generator serves both directions; a side starting mid-transfer of the other runs up to half a bit early
  assign baudClear = ~st_r.rxCtl[RXC_ACTIVE] & ~st_r.txCtl[TXC_RUN];

  asu_baud_gen u_baud (
    .clk_sys(clk_sys),
    .srst(srst),
    .clear(baudClear),
    .reload(st_r.baudReload),
    .prescaleSel(st_r.rxCtl[RXC_PRESCALE]),
    .halfTick(halfTick)
  );

  // ----------------------------------------------------------------
  // shared decode
  // ----------------------------------------------------------------
  always_comb begin
    // forbidden both-set code falls back to eight bits
    if (st_r.txCtl[TXC_LEN_NINE] & ~st_r.txCtl[TXC_LEN_SEVEN]) begin
      dataLen = LEN_NINE;
    end else if (~st_r.txCtl[TXC_LEN_NINE] & st_r.txCtl[TXC_LEN_SEVEN]) begin
      dataLen = LEN_SEVEN;
    end else begin
      dataLen = LEN_EIGHT;
    end
  end

  assign wrRxCtl = regWr && (regAddr == RX_CONTROL_OFS);
  assign wrTxCtl = regWr && (regAddr == TX_CONTROL_OFS);
  assign rxSamples = dataLen + 4'h2;

  // tx frame: start bit, data lsb first, ninth bit, stop ones; no parity
  always_comb begin
    frameBits = '1;
    frameBits[0] = 1'b0;
    if (dataLen == LEN_SEVEN) begin
      frameBits[7:1] = st_r.txHold[6:0];
    end else begin
      frameBits[8:1] = st_r.txHold;
    end
    if (dataLen == LEN_NINE) begin
      frameBits[9] = st_r.txCtl[TXC_NINTH];
    end
  end

  // receive data sits at the top of the shifter; the stop sample is not in it yet at frame end
  assign rxShifted = st_r.rxShift >> (4'hb - dataLen);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    rxEnd = 1'b0;
    rxAbort = 1'b0;
    startSeen = 1'b0;

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    // register writes first; hardware events below override them
    if (regWr) begin
      case (regAddr)
        RX_CONTROL_OFS: begin
          // software may only clear the active flag, which aborts
          st_nxt.rxCtl = {regWrData[7:6], st_r.rxCtl[RXC_ACTIVE] & regWrData[5], regWrData[4:0]};
        end
        TX_CONTROL_OFS: begin
          st_nxt.txCtl = regWrData;
        end
        BAUD_RELOAD_OFS: begin
          st_nxt.baudReload = regWrData;
        end
        TX_HOLDING_OFS: begin
          st_nxt.txHold = regWrData;
        end
        RX_HOLDING_OFS: begin
          st_nxt.rxHold = regWrData;
        end
        default: begin
        end
      endcase
    end

    // --------------------------------------------------------------
    // read port
    // --------------------------------------------------------------
    // read data valid in the next cycle only
    st_nxt.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        RX_CONTROL_OFS: begin
          st_nxt.rdData = st_r.rxCtl;
        end
        TX_CONTROL_OFS: begin
          st_nxt.rdData = st_r.txCtl;
        end
        BAUD_RELOAD_OFS: begin
          st_nxt.rdData = st_r.baudReload;
        end
        TX_HOLDING_OFS: begin
          st_nxt.rdData = st_r.txHold;
        end
        RX_HOLDING_OFS: begin
          st_nxt.rdData = st_r.rxHold;
        end
        default: begin
          st_nxt.rdData = 8'h00;
        end
      endcase
    end

    // --------------------------------------------------------------
    // transmitter
    // --------------------------------------------------------------
    case (st_r.txState)
      TX_IDLE: begin
        if (st_r.txCtl[TXC_RUN] && st_nxt.txCtl[TXC_RUN]) begin
          // length and ninth bit are frozen here; later control writes leave the frame alone
          st_nxt.txShift = frameBits;
          st_nxt.txCnt = dataLen + 4'h2;
          st_nxt.txHalf = 1'b0;
          st_nxt.txExtra = 1'b0;
          st_nxt.txCtl[TXC_LOADED] = 1'b1;
          st_nxt.txState = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (!st_nxt.txCtl[TXC_RUN]) begin
          st_nxt.txState = TX_IDLE;
        end else if (halfTick) begin
          st_nxt.txHalf = ~st_r.txHalf;
          if (st_r.txHalf) begin
            st_nxt.txShift = {1'b1, st_r.txShift[SHIFT_W-1:1]};
            st_nxt.txCnt = st_r.txCnt - 4'h1;
            if (st_r.txCnt == 4'h1) begin
              if (!st_r.txCtl[TXC_LOADED] && !st_r.txExtra) begin
                // next frame queued: hold the line for a second stop bit
                st_nxt.txCnt = 4'h1;
                st_nxt.txExtra = 1'b1;
              end else begin
                st_nxt.txState = TX_IDLE;
                // re-arm costs one idle cycle before the reload
                st_nxt.txCtl[TXC_RUN] = !st_r.txCtl[TXC_LOADED] && !wrTxCtl;
              end
            end
          end
        end
      end
      default: begin
        st_nxt.txState = TX_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // receiver
    // --------------------------------------------------------------
    // edge history resets to the idle high level, so no false start follows reset
    st_nxt.rxPinPrev = rxPin;
    st_nxt.startDetPrev = st_r.rxCtl[RXC_START_DET];
    case (st_r.rxState)
      RX_IDLE: begin
        // falling edge, or enabling detection while the line is low
        if (st_r.rxCtl[RXC_START_DET] && !rxPin && (st_r.rxPinPrev || !st_r.startDetPrev)) begin
          startSeen = 1'b1;
        end
        if (startSeen && !st_r.rxCtl[RXC_ACTIVE]) begin
          st_nxt.rxCtl[RXC_ACTIVE] = 1'b1;
          st_nxt.rxState = RX_RUN;
          st_nxt.rxCnt = rxSamples;
          st_nxt.rxSkip = 1'b0;
          st_nxt.rxShift = '0;
        end
      end
      RX_RUN: begin
        if (!st_nxt.rxCtl[RXC_ACTIVE]) begin
          rxAbort = 1'b1;
        end else if (halfTick) begin
          st_nxt.rxSkip = ~st_r.rxSkip;
          if (!st_r.rxSkip) begin
            st_nxt.rxShift = {rxPin, st_r.rxShift[SHIFT_W-1:1]};
            st_nxt.rxLast = rxPin;
            st_nxt.rxPrev = st_r.rxLast;
            st_nxt.rxCnt = st_r.rxCnt - 4'h1;
            if (st_r.rxCnt == 4'h1) begin
              rxEnd = 1'b1;
            end
          end
        end
      end
      default: begin
        st_nxt.rxState = RX_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // receive completion
    // --------------------------------------------------------------
    if (rxEnd || rxAbort) begin
      st_nxt.rxState = RX_IDLE;
      st_nxt.rxCtl[RXC_ACTIVE] = 1'b0;
      // flag sets win over a clear written in the same cycle
      st_nxt.rxCtl[RXC_DONE] = 1'b1;
      // an abort hands over the partial shift, aligned as for a full frame
      st_nxt.rxHold = rxShifted[7:0];
      if (dataLen == LEN_SEVEN) begin
        st_nxt.rxHold[7] = 1'b0;
      end
      if (rxEnd ? !rxPin : !st_r.rxLast) begin
        st_nxt.rxCtl[RXC_STOP_ERR] = 1'b1;
      end
      if (rxAbort) begin
        st_nxt.rxCtl[RXC_NINTH] = st_r.rxPrev;
      end else if (dataLen == LEN_NINE) begin
        st_nxt.rxCtl[RXC_NINTH] = st_nxt.rxShift[9];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{rxCtl: RX_CONTROL_RST, txCtl: TX_CONTROL_RST, baudReload: BAUD_RELOAD_RST,
                txHold: TX_HOLDING_RST, rxHold: RX_HOLDING_RST, rdData: 8'h00,
                txState: TX_IDLE, txShift: '1, txCnt: 4'h0, txHalf: 1'b0, txExtra: 1'b0,
                rxState: RX_IDLE, rxShift: '0, rxCnt: 4'h0, rxSkip: 1'b0, rxLast: 1'b1,
                rxPrev: 1'b1, rxPinPrev: 1'b1, startDetPrev: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pins and requests
  // ----------------------------------------------------------------
  assign txLine = (st_r.txState == TX_SHIFT) ? st_r.txShift[0] : 1'b1;
  assign pinRouted = st_r.txCtl[TXC_PIN_EN] && !txPortDirection;

  always_comb begin
    if (!pinRouted) begin
      txPinOut = 1'b0;
      txPinOe = 1'b0;
    end else if (st_r.txCtl[TXC_OUT_TYPE]) begin
      txPinOut = txLine;
      txPinOe = 1'b1;
    end else begin
      // open drain only pulls low; a high bit releases the line
      txPinOut = 1'b0;
      txPinOe = !txLine;
    end
  end

  assign rxIrq = st_r.rxCtl[RXC_IRQ_EN] & st_r.rxCtl[RXC_DONE];
  assign txIrq = st_r.txCtl[TXC_IRQ_EN] & st_r.txCtl[TXC_LOADED];
  assign regRdData = st_r.rdData;
endmodule : asu_uart

/* sim/asu_uart_chk.sv */
// asu_uart_chk: port-level assertions for the async serial unit
`timescale 1ns/1ps
module asu_uart_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [asu_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic rxPin,
  input wire logic txPortDirection,
  input wire logic txPinOut,
  input wire logic txPinOe,
  input wire logic rxIrq,
  input wire logic txIrq
);
  import asu_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic rdTx;
  logic rdRx;
  assign rdTx = regRd && regAddr == TX_CONTROL_OFS;
  assign rdRx = regRd && regAddr == RX_CONTROL_OFS;
  // read data reflect the registers of the read cycle, so compare against $past of the pins
  a_dir_blocks_pin: assert property (txPortDirection |-> !txPinOe && !txPinOut)
    else $error("tx pin driven with direction set");
  a_rx_irq_done: assert property (rdRx |=> (regRdData[RXC_DONE] && regRdData[RXC_IRQ_EN]) == $past(rxIrq))
    else $error("rx irq differs from enable and done");
  a_tx_irq_loaded: assert property (rdTx |=> (regRdData[TXC_LOADED] && regRdData[TXC_IRQ_EN]) == $past(txIrq))
    else $error("tx irq differs from enable and loaded");
  a_pin_enable_off: assert property (rdTx |=> regRdData[TXC_PIN_EN] || !$past(txPinOe))
    else $error("tx pin driven with pin enable clear");
  a_idle_push_high: assert property (rdTx |=> {regRdData[TXC_RUN], regRdData[TXC_PIN_EN], regRdData[TXC_OUT_TYPE]} != 3'b011
    || $past(txPortDirection) || ($past(txPinOe) && $past(txPinOut)))
    else $error("idle push-pull pin not high");
  a_idle_drain_off: assert property (rdTx |=> {regRdData[TXC_RUN], regRdData[TXC_PIN_EN], regRdData[TXC_OUT_TYPE]} != 3'b010
    || !$past(txPinOe))
    else $error("idle open drain pin not released");
  a_drain_low_only: assert property (rdTx |=> !regRdData[TXC_PIN_EN] || regRdData[TXC_OUT_TYPE]
    || !$past(txPinOe) || !$past(txPinOut))
    else $error("open drain pin driven high");
  a_abort_idle: assert property ((regWr && regAddr == TX_CONTROL_OFS && regWrData[7:4] == 4'h3 && !txPortDirection)
    ##1 !txPortDirection [*2] |-> txPinOe && txPinOut)
    else $error("pin not idle after run cleared");
endmodule : asu_uart_chk

bind asu_uart asu_uart_chk u_asu_uart_chk (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxPin(rxPin),
  .txPortDirection(txPortDirection), .txPinOut(txPinOut), .txPinOe(txPinOe), .rxIrq(rxIrq), .txIrq(txIrq));

/* sim/asu_remote.sv */
// asu_remote: remote serial transceiver model at the far end of the line
`timescale 1ns/1ps
module asu_remote (
  input wire logic clk_sys,
  input wire logic txLine,
  output logic rxLine
);
  int bitCyc = 8; // one bit period in system cycles, matches the bench baud setting
  initial rxLine = 1'b1;
  // start, data lsb first, no parity, one stop of chosen level
  task automatic send(input logic [8:0] data, input int nBits, input logic stopBit);
    rxLine <= 1'b0;
    repeat (bitCyc) @(posedge clk_sys);
    for (int i = 0; i < nBits; i++) begin
      rxLine <= data[i];
      repeat (bitCyc) @(posedge clk_sys);
    end
    rxLine <= stopBit;
    repeat (bitCyc) @(posedge clk_sys);
    rxLine <= 1'b1;
  endtask : send
  // samples near bit centres; bounded wait so a silent line cannot hang
  task automatic listen(input int nBits, output logic [8:0] data, output logic stopBit, output time t0);
    int n = 0;
    data = 9'h000;
    while (txLine !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    t0 = $time;
    repeat (bitCyc / 2) @(posedge clk_sys);
    for (int i = 0; i < nBits; i++) begin
      repeat (bitCyc) @(posedge clk_sys);
      data[i] = txLine;
    end
    repeat (bitCyc) @(posedge clk_sys);
    stopBit = txLine;
  endtask : listen
endmodule : asu_remote

/* sim/tb_asu_uart.sv */
// tb_asu_uart: self-checking bench for the async serial unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_asu_uart;
  import asu_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic txPortDirection = 1'b0;
  wire logic [7:0] regRdData;
  wire logic rxPin;
  wire logic txPinOut;
  wire logic txPinOe;
  wire logic rxIrq;
  wire logic txIrq;
  wire logic txWire = txPinOe ? txPinOut : 1'b1; // pulled up while released
  int failures = 0;
  int cmpCount = 0;
  always #25 clk_sys = ~clk_sys;
  asu_uart u_asu_uart (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxPin(rxPin), .txPortDirection(txPortDirection),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .rxIrq(rxIrq), .txIrq(txIrq));
  asu_remote u_asu_remote (.clk_sys(clk_sys), .txLine(txWire), .rxLine(rxPin));
  // gap cycle after each write keeps strobes from being reassigned in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    // take the data mid-cycle, away from the edge that drops it
    @(negedge clk_sys);
    d = regRdData;
    @(posedge clk_sys);
  endtask : rd
  task automatic test_regs;
    logic [7:0] val [4] = '{8'h02, 8'hc3, 8'h96, 8'hff}; // baud 2 gives an 8-cycle bit, never zero
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      rd(RX_CONTROL_OFS + 16'(i), v);
      `CHK("reset value", 8'h00, v)
    end
    for (int i = 0; i < 4; i++) begin
      wr(BAUD_RELOAD_OFS + 16'(i), val[i]);
      rd(BAUD_RELOAD_OFS + 16'(i), v);
      `CHK("readback", (i == 3) ? 8'h00 : val[i], v)
    end
  endtask : test_regs
  task automatic test_tx;
    logic [7:0] ctl [3] = '{8'hb1, 8'hf5, 8'hb9};
    logic [7:0] dat [3] = '{8'ha5, 8'h3c, 8'hd5};
    int nb [3] = '{8, 9, 7};
    logic [8:0] ex [3] = '{9'h0a5, 9'h13c, 9'h055};
    logic [8:0] got;
    logic stp;
    time t0;
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      wr(TX_HOLDING_OFS, dat[i]);
      wr(TX_CONTROL_OFS, ctl[i]);
      u_asu_remote.listen(nb[i], got, stp, t0);
      `CHK("tx data", ex[i], got)
      `CHK("tx stop", 1'b1, stp)
      repeat (8) @(posedge clk_sys);
      rd(TX_CONTROL_OFS, v);
      `CHK("tx control", (ctl[i] & 8'h7f) | 8'h02, v)
      `CHK("tx irq", 1'b1, txIrq)
      wr(TX_CONTROL_OFS, 8'h30);
    end
  endtask : test_tx
  task automatic test_cont;
    logic [8:0] a;
    logic [8:0] b;
    logic s1;
    logic s2;
    time t1;
    time t2;
    logic [7:0] v = 8'h00;
    int n = 0;
    wr(TX_HOLDING_OFS, 8'h11);
    wr(TX_CONTROL_OFS, 8'hb0);
    fork
      begin
        u_asu_remote.listen(8, a, s1, t1);
        u_asu_remote.listen(8, b, s2, t2);
      end
      begin
        while (v[TXC_LOADED] !== 1'b1 && n < 20) begin
          rd(TX_CONTROL_OFS, v);
          n++;
        end
        wr(TX_HOLDING_OFS, 8'h22);
        wr(TX_CONTROL_OFS, 8'hb0);
      end
    join
    repeat (12) @(posedge clk_sys);
    `CHK("first frame", 9'h011, a)
    `CHK("second frame", 9'h022, b)
    // 11 bits of 8 cycles plus the one-cycle gap; one extra cycle of load allowed
    `CHK("frame spacing", 1'b1, (t2 - t1) inside {[4450:4500]})
  endtask : test_cont
  task automatic test_pin;
    logic [7:0] v;
    wr(TX_CONTROL_OFS, 8'hb0);
    repeat (20) @(posedge clk_sys);
    wr(TX_CONTROL_OFS, 8'h30);
    @(posedge clk_sys);
    `CHK("pin after abort", 2'b11, {txPinOe, txPinOut})
    rd(TX_CONTROL_OFS, v);
    `CHK("run after abort", 8'h30, v)
    txPortDirection <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    `CHK("pin with direction", 1'b0, txPinOe)
    txPortDirection <= 1'b0;
    wr(TX_CONTROL_OFS, 8'h20);
    rd(TX_CONTROL_OFS, v);
    `CHK("open drain idle", 1'b0, txPinOe)
    wr(TX_CONTROL_OFS, 8'h00);
    rd(TX_CONTROL_OFS, v);
    `CHK("pin disabled", 1'b0, txPinOe)
  endtask : test_pin
  task automatic test_slow;
    logic [8:0] got;
    logic stp;
    time t0;
    wr(RX_CONTROL_OFS, 8'h80);
    wr(TX_HOLDING_OFS, 8'h69);
    u_asu_remote.bitCyc = 32;
    wr(TX_CONTROL_OFS, 8'hb0);
    u_asu_remote.listen(8, got, stp, t0);
    `CHK("slow tx data", 9'h069, got)
    `CHK("slow tx stop", 1'b1, stp)
    repeat (32) @(posedge clk_sys);
    u_asu_remote.bitCyc = 8;
    wr(RX_CONTROL_OFS, 8'h00);
  endtask : test_slow
  task automatic test_abort;
    logic [7:0] v;
    wr(TX_CONTROL_OFS, 8'h00);
    wr(RX_CONTROL_OFS, 8'h41);
    fork
      u_asu_remote.send(9'h00f, 8, 1'b1);
      begin
        // lands between the samples of data bits 4 and 5
        repeat (50) @(posedge clk_sys);
        wr(RX_CONTROL_OFS, 8'h41);
      end
    join
    repeat (4) @(posedge clk_sys);
    rd(RX_CONTROL_OFS, v);
    `CHK("rx abort control", 8'h57, v)
    `CHK("rx abort irq", 1'b1, rxIrq)
  endtask : test_abort
  task automatic test_rx;
    logic [7:0] len [4] = '{8'h00, 8'h00, 8'h08, 8'h40};
    logic [8:0] dat [4] = '{9'h055, 9'h0f0, 9'h07f, 9'h1aa};
    int nb [4] = '{8, 8, 7, 9};
    logic stp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [7:0] hold [4] = '{8'h55, 8'hf0, 8'h7f, 8'haa};
    logic [7:0] ctl [4] = '{8'h43, 8'h53, 8'h43, 8'h47};
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      wr(TX_CONTROL_OFS, len[i]);
      wr(RX_CONTROL_OFS, 8'h41);
      u_asu_remote.send(dat[i], nb[i], stp[i]);
      repeat (4) @(posedge clk_sys);
      rd(RX_HOLDING_OFS, v);
      `CHK("rx data", hold[i], v)
      rd(RX_CONTROL_OFS, v);
      `CHK("rx control", ctl[i], v)
      `CHK("rx irq", 1'b1, rxIrq)
    end
  endtask : test_rx
  task automatic results;
    if (failures == 0 && cmpCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    test_regs();
    test_tx();
    test_cont();
    test_pin();
    test_slow();
    test_rx();
    test_abort();
    results();
  end
  // whole run needs under two thousand cycles; this bound only catches a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    results();
  end
endmodule : tb_asu_uart
